/* design/hbfp_top.sv */
// fault protection and output gating of a six-pair half-bridge driver
`timescale 1ns/1ps
`include "hbfp_defs.svh"
module hbfp_top
  import hbfp_pkg::*;
#(
  parameter int UL_DELAY_CYC = `HBFP_UL_DELAY_CYC
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_chip_select_n,
  input  wire logic                      i_sclk,
  input  wire logic                      i_serial_in,
  input  wire logic                      i_enable,
  input  wire logic                      i_vcc_undervoltage,
  input  wire logic                      i_undervoltage_lockout,
  input  wire logic                      i_driver_supply_a_ov,
  input  wire logic                      i_driver_supply_b_ov,
  input  wire hbfp_pkg::hbfp_chan_t      i_overcurrent,
  input  wire hbfp_pkg::hbfp_chan_t      i_underload,
  input  wire logic [`HBFP_SENS_N-1:0]   i_temp_warning,
  input  wire logic [`HBFP_SENS_N-1:0]   i_temp_over,
  output hbfp_pkg::hbfp_chan_t           o_half_bridge_output,
  output logic                           o_serial_out,
  output logic                           o_serial_out_oe
);

  // ----------------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 8 + 2 * `HBFP_CH_N + 2 * `HBFP_SENS_N;
  localparam int UL_W   = $clog2(UL_DELAY_CYC + 1);
  localparam logic [UL_W-1:0] UL_LIMIT = UL_W'(UL_DELAY_CYC);

  // hardware set wins over software clear
  function automatic logic sticky(
    input logic flag,
    input logic set,
    input logic clr
  );
    sticky = (flag & ~clr) | set;
  endfunction : sticky

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;

  // select enters inverted so a reset sync reads as deselected
  assign pins_raw = {
    ~i_chip_select_n,
    i_sclk,
    i_serial_in,
    i_enable,
    i_vcc_undervoltage,
    i_undervoltage_lockout,
    i_driver_supply_a_ov,
    i_driver_supply_b_ov,
    i_overcurrent,
    i_underload,
    i_temp_warning,
    i_temp_over
  };

  hbfp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk   (i_ref_clk),
    .i_rst   (i_sys_rst),
    .i_async (pins_raw),
    .o_sync  (pins_s)
  );

  wire cs_n_s = ~pins_s[SYNC_W-1];
  wire sclk_s = pins_s[SYNC_W-2];
  wire si_s   = pins_s[SYNC_W-3];
  wire en_s   = pins_s[SYNC_W-4];
  wire vcc_uv_s = pins_s[SYNC_W-5];
  wire drv_uv_s = pins_s[SYNC_W-6];
  wire ov_a_s = pins_s[SYNC_W-7];
  wire ov_b_s = pins_s[SYNC_W-8];

  hbfp_chan_t               oc_s;
  hbfp_chan_t               ul_s;
  logic [`HBFP_SENS_N-1:0]  tw_s;
  logic [`HBFP_SENS_N-1:0]  ot_s;

  assign {oc_s, ul_s, tw_s, ot_s} = pins_s[SYNC_W-9:0];

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  hbfp_word_t status_word;
  hbfp_word_t rx_word;
  logic       rx_valid;

  hbfp_spi u_spi (
    .i_clk        (i_ref_clk),
    .i_rst        (i_sys_rst),
    .i_cs_n       (cs_n_s),
    .i_sclk       (sclk_s),
    .i_si         (si_s),
    .i_status     (status_word),
    .o_so         (o_serial_out),
    .o_so_oe      (o_serial_out_oe),
    .o_word       (rx_word),
    .o_word_valid (rx_valid)
  );

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  hbfp_word_t  ctrl_reg;
  hbfp_word_t  ctrl_next;
  hbfp_chan_t  latch_reg;
  hbfp_chan_t  latch_next;
  hbfp_chan_t  out_reg;
  hbfp_chan_t  out_next;
  logic        tw_reg;
  logic        tw_next;
  logic        old_reg;
  logic        old_next;
  logic        ul_reg;
  logic        ul_next;
  logic        psf_reg;
  logic        psf_next;
  logic [UL_W-1:0] ul_cnt_reg [`HBFP_CH_N];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // vcc lockout or sleep both wipe the logic
  wire lockout = vcc_uv_s | ~en_s;
  wire accept  = rx_valid & ~lockout;
  wire status_clear_command     = accept & rx_word[`HBFP_BIT_TW];

  wire ocd_en  = ctrl_reg[`HBFP_BIT_OCD];
  wire uld_en  = ctrl_reg[`HBFP_BIT_ULD];
  wire overvoltage_shutdown_enable_en = ctrl_reg[`HBFP_BIT_OVERVOLTAGE_SHUTDOWN_ENABLE];

  hbfp_chan_t sel;
  assign sel = ctrl_reg[`HBFP_CH_N:1];

  wire ov_s  = ov_a_s | ov_b_s;
  wire tsd_s = |ot_s;
  wire twa_s = |tw_s;

  // overcurrent only counts on a driven output
  hbfp_chan_t oc_hit;
  assign oc_hit = oc_s & out_reg;

  wire hbfp_chan_t ul_evt;
  generate
    for (genvar g = 0; g < `HBFP_CH_N; g++) begin : g_ul
      assign ul_evt[g] = out_reg[g] & ul_s[g] &
                         (ul_cnt_reg[g] == UL_LIMIT);
    end
  endgenerate

  // latch-off sources
  hbfp_chan_t oc_latch;
  hbfp_chan_t ul_latch;
  assign oc_latch = oc_hit & {`HBFP_CH_N{ocd_en}};
  assign ul_latch = ul_evt & {`HBFP_CH_N{uld_en}};

  // global drive permission; selection untouched by faults
  wire drv_ok = ~lockout & ~drv_uv_s & ~tsd_s &
                ~(ov_s & overvoltage_shutdown_enable_en);

  // ----------------------------------------------------------------
  // next-state
  // ----------------------------------------------------------------
  // selection changes only by a frame or a logic wipe
  assign ctrl_next = lockout ? `HBFP_WORD_RST :
                     accept  ? {rx_word[`HBFP_WORD_W-1:1], 1'b0} :
                               ctrl_reg;

  // latches cleared only by status clear or a logic wipe
  assign latch_next = lockout ? `HBFP_CH_RST :
                      ((latch_reg & {`HBFP_CH_N{~status_clear_command}}) |
                       oc_latch | ul_latch);

  assign out_next = sel & ~latch_reg &
                    {`HBFP_CH_N{drv_ok}};

  assign old_next = ~lockout &
                    sticky(old_reg, |oc_hit, status_clear_command);
  assign ul_next  = ~lockout &
                    sticky(ul_reg, |ul_evt, status_clear_command);
  assign psf_next = ~lockout &
                    sticky(psf_reg, ov_s | drv_uv_s, status_clear_command);
  assign tw_next  = ~lockout &
                    sticky(tw_reg, twa_s, status_clear_command);

  assign status_word = {psf_reg, ul_reg, old_reg,
                        out_reg, tw_reg};

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg  <= `HBFP_WORD_RST;
      latch_reg <= `HBFP_CH_RST;
      out_reg   <= `HBFP_CH_RST;
      tw_reg    <= 1'b0;
      old_reg   <= 1'b0;
      ul_reg    <= 1'b0;
      psf_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      latch_reg <= latch_next;
      out_reg   <= out_next;
      tw_reg    <= tw_next;
      old_reg   <= old_next;
      ul_reg    <= ul_next;
      psf_reg   <= psf_next;
    end
  end

  // underload delay per channel, saturating at the limit
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `HBFP_CH_N; i++) begin
        ul_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `HBFP_CH_N; i++) begin
        if (!(out_reg[i] && ul_s[i])) begin
          ul_cnt_reg[i] <= '0;
        end else if (ul_cnt_reg[i] != UL_LIMIT) begin
          ul_cnt_reg[i] <= ul_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  assign o_half_bridge_output = out_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_ov_event;
    ov_s && !lockout;
  endsequence

  sequence s_quiet;
    !accept && !lockout;
  endsequence

  a_off_in_lockout: assert property (
    lockout |=> out_reg == '0)
    else $error("output on during lockout");

  a_wipe_selection: assert property (
    lockout |=> ctrl_reg == '0 && !tw_reg && !psf_reg)
    else $error("state kept through lockout");

  a_ctrl_stable: assert property (
    s_quiet |=> ctrl_reg == $past(ctrl_reg))
    else $error("selection changed without a frame");

  a_ocd_latch: assert property (
    (oc_latch != '0) && !lockout |=>
      (latch_reg & $past(oc_latch)) == $past(oc_latch) ##1
      (out_reg & $past(oc_latch, 2)) == '0)
    else $error("overcurrent output not latched off");

  a_ocd_disabled: assert property (
    !ocd_en && (ul_latch == '0) && !status_clear_command && !lockout |=>
      latch_reg == $past(latch_reg))
    else $error("overcurrent latched with shutdown off");

  a_old_sticky: assert property (
    old_reg && !status_clear_command && !lockout |=> old_reg)
    else $error("overload flag lost without clear");

  a_ov_flag: assert property (
    s_ov_event |=> psf_reg)
    else $error("supply fail flag not set");

  a_ov_forced_off: assert property (
    s_ov_event ##0 overvoltage_shutdown_enable_en |=> out_reg == '0)
    else $error("output on during overvoltage");

  a_tsd_all_off: assert property (
    tsd_s |=> out_reg == '0)
    else $error("output on during thermal shutdown");

  a_resume_sel: assert property (
    drv_ok && $stable(sel) && $stable(latch_reg) [*2] |=>
      out_reg == $past(sel & ~latch_reg))
    else $error("output not following selection");

  a_tw_keeps_on: assert property (
    twa_s && drv_ok |=> tw_reg ##0 out_reg == $past(sel & ~latch_reg))
    else $error("thermal warning mishandled");

  a_srr_clears: assert property (
    status_clear_command && !twa_s && !ov_s && !drv_uv_s && oc_hit == '0 &&
      ul_evt == '0 |=> !tw_reg && !psf_reg && !old_reg && !ul_reg)
    else $error("status clear left a flag set");

  a_ul_flag_set: assert property (
    (ul_evt != '0) && !lockout |=> ul_reg)
    else $error("underload flag not set");

  a_status_out: assert property (
    status_word[`HBFP_CH_N:1] == out_reg)
    else $error("status word differs from outputs");

endmodule : hbfp_top

/* design/hbfp_defs.svh */
// constants for the half-bridge fault protection block
`ifndef HBFP_DEFS_SVH
`define HBFP_DEFS_SVH
`define HBFP_WORD_W        16
`define HBFP_CH_N          12
`define HBFP_SENS_N        6
`define HBFP_BIT_TW        0
`define HBFP_BIT_OCD       13
`define HBFP_BIT_ULD       14
`define HBFP_BIT_OVERVOLTAGE_SHUTDOWN_ENABLE      15
`define HBFP_WORD_RST      16'h0000
`define HBFP_CH_RST        12'h000
`define HBFP_CNT_W         4
`define HBFP_CLK_PERIOD_PS 8000
`define HBFP_UL_DELAY_NS   20000
`define HBFP_UL_DELAY_CYC  \
  ((`HBFP_UL_DELAY_NS * 1000 + `HBFP_CLK_PERIOD_PS - 1) / `HBFP_CLK_PERIOD_PS)
`endif

/* design/hbfp_pkg.sv */
// types shared by the half-bridge fault protection modules
`include "hbfp_defs.svh"
package hbfp_pkg;
  typedef logic [`HBFP_WORD_W-1:0] hbfp_word_t;
  typedef logic [`HBFP_CH_N-1:0]   hbfp_chan_t;
  typedef enum logic {
    HBFP_SPI_IDLE  = 1'b0,
    HBFP_SPI_FRAME = 1'b1
  } hbfp_spi_state_e;
endpackage : hbfp_pkg

/* design/hbfp_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module hbfp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : hbfp_sync

/* design/hbfp_spi.sv */
// serial frame receiver and fault word shifter
`timescale 1ns/1ps
`include "hbfp_defs.svh"
module hbfp_spi
  import hbfp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_si,
  input  wire hbfp_pkg::hbfp_word_t i_status,
  output logic                   o_so,
  output logic                   o_so_oe,
  output hbfp_pkg::hbfp_word_t   o_word,
  output logic                   o_word_valid
);
  hbfp_spi_state_e          state_reg;
  hbfp_word_t               sr_reg;
  logic [`HBFP_CNT_W-1:0]   cnt_reg;
  logic                     full_reg;
  logic                     cs_d_reg;
  logic                     sclk_d_reg;

  wire cs_fall   = cs_d_reg & ~i_cs_n;
  wire cs_rise   = ~cs_d_reg & i_cs_n;
  wire sclk_fall = sclk_d_reg & ~i_sclk;
  wire in_frame  = (state_reg == HBFP_SPI_FRAME);
  wire last_bit  = (cnt_reg == {`HBFP_CNT_W{1'b1}});
  wire frame_ok  = full_reg & (cnt_reg == '0);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg    <= HBFP_SPI_IDLE;
      sr_reg       <= `HBFP_WORD_RST;
      cnt_reg      <= '0;
      full_reg     <= 1'b0;
      cs_d_reg     <= 1'b1;
      sclk_d_reg   <= 1'b0;
      o_so         <= 1'b0;
      o_so_oe      <= 1'b0;
      o_word       <= `HBFP_WORD_RST;
      o_word_valid <= 1'b0;
    end else begin
      cs_d_reg     <= i_cs_n;
      sclk_d_reg   <= i_sclk;
      o_word_valid <= 1'b0;
      unique case (state_reg)
        HBFP_SPI_IDLE: begin
          if (cs_fall) begin
            state_reg <= HBFP_SPI_FRAME;
            sr_reg    <= i_status;
            o_so      <= i_status[`HBFP_BIT_TW];
            o_so_oe   <= 1'b1;
            cnt_reg   <= '0;
            full_reg  <= 1'b0;
          end
        end
        HBFP_SPI_FRAME: begin
          if (cs_rise) begin
            state_reg    <= HBFP_SPI_IDLE;
            o_so_oe      <= 1'b0;
            o_word       <= sr_reg;
            o_word_valid <= frame_ok;
          end else if (sclk_fall) begin
            sr_reg   <= {i_si, sr_reg[`HBFP_WORD_W-1:1]};
            o_so     <= sr_reg[1];
            cnt_reg  <= cnt_reg + 1'b1;
            full_reg <= full_reg | last_bit;
          end
        end
      endcase
    end
  end

  sequence s_cs_fall;
    !in_frame && cs_fall;
  endsequence

  a_tw_on_select: assert property (@(posedge i_clk) disable iff (i_rst)
    s_cs_fall |=> o_so_oe && (o_so == $past(i_status[`HBFP_BIT_TW])))
    else $error("thermal warning not shown on select fall");

  a_word_whole_frame: assert property (@(posedge i_clk) disable iff (i_rst)
    o_word_valid |-> $past(in_frame) && $past(cs_rise) && $past(frame_ok))
    else $error("control word taken from a partial frame");
endmodule : hbfp_spi

/* testbench/hbfp_spi_master.sv */
// serial master model that drives the control port of the block
`timescale 1ns/1ps
module hbfp_spi_master (
  input  wire logic i_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_si
);
  // released data line floats: show the inverse of the driven level
  wire so_line = i_so_oe ? i_so : ~i_so;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si   = 1'b0;
  end

  // ---------------------------------------------------------------
  // frame of nbits, lsb first, data held across each falling clock
  // ---------------------------------------------------------------
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    for (int b = 0; b < nbits; b++) begin
      o_si   <= word[b % 16];
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      rx[b % 16] = so_line;
      @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (5) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_si   <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : xfer

  // ---------------------------------------------------------------
  // select low without any clock: sample the early warning level
  // ---------------------------------------------------------------
  task automatic peek(output logic seen, output logic oe);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    seen = so_line;
    oe   = i_so_oe;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : peek
endmodule : hbfp_spi_master

/* testbench/half_bridge_fault_protection_bench.sv */
// self-checking bench with a behavioural model of the protection block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module half_bridge_fault_protection_bench;
  import hbfp_pkg::*;
  localparam int UL_CYC = 20;
  logic        clk, rst, cs_n, sclk, si, en, vcc_uv, drv_uv, ov_a, ov_b;
  logic        so, so_oe, power_supply_fail_flag, ulf, ovf, twf, seen, oe_seen;
  hbfp_chan_t  oc, ul, outs;
  logic [5:0]  tw_in, tover;
  logic [15:0] ctrl, rx;
  logic [11:0] latch, sel;
  int          fails = 0;
  int          checked = 0;
  int          ch;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  hbfp_top #(.UL_DELAY_CYC(UL_CYC)) DUT (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_chip_select_n(cs_n),
    .i_sclk(sclk), .i_serial_in(si), .i_enable(en),
    .i_vcc_undervoltage(vcc_uv), .i_undervoltage_lockout(drv_uv),
    .i_driver_supply_a_ov(ov_a), .i_driver_supply_b_ov(ov_b),
    .i_overcurrent(oc), .i_underload(ul), .i_temp_warning(tw_in),
    .i_temp_over(tover), .o_half_bridge_output(outs),
    .o_serial_out(so), .o_serial_out_oe(so_oe));

  hbfp_spi_master master (.i_clk(clk), .i_so(so), .i_so_oe(so_oe),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));

  // ---------------------------------------------------------------
  // model
  // ---------------------------------------------------------------
  function automatic logic [11:0] exp_out();
    if (drv_uv || (|tover) || ((ov_a || ov_b) && ctrl[15]))
      return 12'h000;
    return ctrl[12:1] & ~latch;
  endfunction : exp_out

  task automatic wipe();
    ctrl  = 16'h0000;
    latch = 12'h000;
    {power_supply_fail_flag, ulf, ovf, twf} = 4'h0;
  endtask : wipe

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic frame(input logic [15:0] w);
    logic [15:0] st;
    st = {power_supply_fail_flag, ulf, ovf, exp_out(), twf};
    master.xfer(w, 16, rx);
    if (en && !vcc_uv) begin
      `CHK("status", st, rx)
      if (w[0]) begin
        latch = 12'h000;
        {power_supply_fail_flag, ulf, ovf, twf} = 4'h0;
      end
      ctrl = w & 16'hFFFE;
    end
    settle();
    `CHK("outputs", exp_out(), outs)
  endtask : frame

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {rst, en, vcc_uv, drv_uv, ov_a, ov_b} = 6'b110000;
    {oc, ul, tw_in, tover} = '0;
    wipe();
    void'($urandom(69664));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("outputs", exp_out(), outs)
    frame(16'h0000);
    $display("test power_up done");

    for (int i = 0; i < 4; i++) begin
      sel = 12'($urandom);
      frame({3'b000, sel, 1'b0});
    end
    master.xfer({3'b000, ~sel, 1'b0}, 8, rx);
    settle();
    `CHK("outputs", exp_out(), outs)
    $display("test control_word done");

    for (int m = 0; m < 2; m++) begin
      ch = $urandom_range(11);
      frame({2'b00, m == 1, 12'hFFF, 1'b0});
      @(posedge clk);
      oc[ch] <= 1'b1;
      repeat (6) @(posedge clk);
      oc[ch] <= 1'b0;
      ovf = 1'b1;
      if (m == 1) latch[ch] = 1'b1;
      settle();
      `CHK("outputs", exp_out(), outs)
      frame({2'b00, m == 1, 12'hFFF, 1'b0});
      frame({2'b00, m == 1, 12'hFFF, 1'b1});
    end
    $display("test overcurrent done");

    ch = $urandom_range(11);
    frame({3'b010, 12'hFFF, 1'b0});
    @(posedge clk);
    ul[ch] <= 1'b1;
    repeat (UL_CYC - 5) @(posedge clk);
    ul[ch] <= 1'b0;
    frame({3'b010, 12'hFFF, 1'b0});
    ul[ch] <= 1'b1;
    repeat (UL_CYC + 10) @(posedge clk);
    ul[ch] <= 1'b0;
    ulf = 1'b1;
    latch[ch] = 1'b1;
    settle();
    `CHK("outputs", exp_out(), outs)
    frame({3'b010, 12'hFFF, 1'b0});
    frame({3'b010, 12'hFFF, 1'b1});
    $display("test underload done");

    sel = 12'($urandom);
    frame({3'b100, sel, 1'b0});
    ov_a <= 1'b1;
    settle();
    power_supply_fail_flag = 1'b1;
    `CHK("outputs", exp_out(), outs)
    ov_a <= 1'b0;
    settle();
    `CHK("outputs", exp_out(), outs)
    frame({3'b000, sel, 1'b0});
    ov_b <= 1'b1;
    settle();
    `CHK("outputs", exp_out(), outs)
    ov_b <= 1'b0;
    drv_uv <= 1'b1;
    settle();
    `CHK("outputs", exp_out(), outs)
    drv_uv <= 1'b0;
    settle();
    `CHK("outputs", exp_out(), outs)
    frame({3'b000, sel, 1'b1});
    $display("test overvoltage done");

    tw_in[$urandom_range(5)] <= 1'b1;
    settle();
    twf = 1'b1;
    `CHK("outputs", exp_out(), outs)
    master.peek(seen, oe_seen);
    `CHK("warning_level", 1'b1, seen)
    `CHK("serial_enable", 1'b1, oe_seen)
    tw_in <= 6'h00;
    for (int s = 0; s < 6; s++) begin
      tover[s] <= 1'b1;
      settle();
      `CHK("outputs", exp_out(), outs)
      tover[s] <= 1'b0;
      settle();
      `CHK("outputs", exp_out(), outs)
    end
    tover[2] <= 1'b1;
    settle();
    sel = 12'($urandom);
    frame({3'b000, sel, 1'b0});
    tover <= 6'h00;
    settle();
    `CHK("outputs", exp_out(), outs)
    frame({3'b000, sel, 1'b0});
    frame({3'b000, sel, 1'b1});
    master.peek(seen, oe_seen);
    `CHK("warning_level", 1'b0, seen)
    $display("test thermal done");

    vcc_uv <= 1'b1;
    settle();
    wipe();
    `CHK("outputs", exp_out(), outs)
    frame(16'h1FFE);
    vcc_uv <= 1'b0;
    settle();
    frame({3'b000, sel, 1'b0});
    en <= 1'b0;
    settle();
    wipe();
    `CHK("outputs", exp_out(), outs)
    en <= 1'b1;
    settle();
    frame(16'h0000);
    $display("test supply_sleep done");
    tally_and_finish();
  end
endmodule : half_bridge_fault_protection_bench
